// ==== core/tpg_pkg.sv ====
// constants for the converter test-pattern generator and its register map.
// assumes a single 40 MHz encode clock and a byte-wide register port.
// How it works
// (RQ1) four-bit mode code, zero means off
// (RQ2) active pattern replaces converter samples
// (RQ3) test-mode bits 4 or 5 reseed PN
// (RQ4) patterns need only the clock, input ignored; the code steps only on adc_valid_i with fifo space
// (RQ5) DDC carries pattern only if bit0 set
// (RQ6) I path pattern, Q path untouched
// (RQ7) fourth DDC bit0 uses channel A pattern
// (RQ8) midscale, positive, negative full-scale shorts
// (RQ9) checkerboard 0x1555 / 0x2AAA alternating
// (RQ10) long PN x^23+x^18+1, seed 0x3AFF
// (RQ11) short PN x^9+x^5+1, seed 0x0092
// (RQ12) word toggle 0x0000 / 0x3FFF
// (RQ13) user patterns 1-4 repeat, bits 15:2
// (RQ14) user patterns single pass then zeros
// (RQ15) ramp increments by one modulo 2^14
// (RQ16) link test pattern via two registers
// (RQ17) leaving link test needs soft reset
// (RQ18) link test bits 3:0 pick pattern
// (RQ19) link test bits 5:4 pick injection point
// (RQ20) generators step per sample, restart on entry
package tpg_pkg;
    localparam int SAMPLE_W = 14;
    localparam int NUM_DDC = 4;
    localparam logic [11:0] ADDR_SOFT_RESET = 12'h000;
    localparam logic [11:0] ADDR_DDC0_CTRL = 12'h327;
    localparam logic [11:0] ADDR_DDC1_CTRL = 12'h347;
    localparam logic [11:0] ADDR_DDC2_CTRL = 12'h367;
    localparam logic [11:0] ADDR_DDC3_CTRL = 12'h387;
    localparam logic [11:0] ADDR_CONV_TEST = 12'h550;
    localparam logic [11:0] ADDR_USER_FIRST = 12'h551;
    localparam logic [11:0] ADDR_USER_LAST = 12'h558;
    localparam logic [11:0] ADDR_LINK_TEST = 12'h573;
    localparam logic [11:0] ADDR_LINK_TEST_EXT = 12'h574;
    localparam logic [7:0] RST_VAL_REG = 8'h00;
    localparam logic [7:0] SOFT_RESET_MASK = 8'h81;
    localparam int POS_PN_RESET_A = 4;
    localparam int POS_PN_RESET_B = 5;
    localparam int POS_USER_SINGLE = 7;
    localparam int POS_DDC_TEST_EN = 0;
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_MIDSCALE = 4'h1;
    localparam logic [3:0] MODE_POS_FS = 4'h2;
    localparam logic [3:0] MODE_NEG_FS = 4'h3;
    localparam logic [3:0] MODE_CHECKER = 4'h4;
    localparam logic [3:0] MODE_PN_LONG = 4'h5;
    localparam logic [3:0] MODE_PN_SHORT = 4'h6;
    localparam logic [3:0] MODE_TOGGLE = 4'h7;
    localparam logic [3:0] MODE_USER = 4'h8;
    localparam logic [3:0] MODE_RAMP = 4'hF;
    localparam logic [13:0] VAL_MIDSCALE = 14'h0000;
    localparam logic [13:0] VAL_POS_FS = 14'h1FFF;
    localparam logic [13:0] VAL_NEG_FS = 14'h2000;
    localparam logic [13:0] VAL_CHECK_A = 14'h1555;
    localparam logic [13:0] VAL_CHECK_B = 14'h2AAA;
    localparam logic [13:0] VAL_ZEROS = 14'h0000;
    localparam logic [13:0] VAL_ONES = 14'h3FFF;
    localparam logic [22:0] PN_LONG_SEED = 23'h003AFF;
    localparam logic [8:0] PN_SHORT_SEED = 9'h092;
    localparam int NUM_USER_PAT = 4;
    localparam int FIFO_DEPTH = 8;
endpackage

// ==== core/tpg_top.sv ====
// test-pattern generator that stands in front of the output formatter, plus its
// output FIFO. assumes the register port, sample and DDC streams share clk_i.
`timescale 1ns/1ps

module tpg_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wr_q] = in_data_i;
            wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
        end
        if (pop) begin
            rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            mem_q <= mem_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    chk_fifo_never_over: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
endmodule

module tpg_top #(
    parameter int SW = tpg_pkg::SAMPLE_W,
    parameter int NDDC = tpg_pkg::NUM_DDC,
    parameter int DEPTH = tpg_pkg::FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic ddc_mode_i,
    input wire logic [NDDC-1:0] ddc_en_i,
    input wire logic adc_valid_i,
    output logic adc_ready_o,
    input wire logic [SW-1:0] adc_data_i,
    input wire logic [NDDC*SW-1:0] ddc_i_data_i,
    input wire logic [NDDC*SW-1:0] ddc_q_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [SW-1:0] out_conv_o,
    output logic [NDDC*SW-1:0] out_ddc_i_o,
    output logic [NDDC*SW-1:0] out_ddc_q_o,
    output logic test_active_o,
    output logic [3:0] link_pattern_o,
    output logic [1:0] link_inject_o,
    output logic [7:0] link_ext_o
);
    localparam int FW = SW + 2 * NDDC * SW;

    logic [7:0] soft_q, soft_d;
    logic [7:0] ddc_ctrl_q [NDDC];
    logic [7:0] ddc_ctrl_d [NDDC];
    logic [7:0] conv_q, conv_d;
    logic [7:0] user_q [2*tpg_pkg::NUM_USER_PAT];
    logic [7:0] user_d [2*tpg_pkg::NUM_USER_PAT];
    logic [7:0] link_q, link_d, link_ext_q, link_ext_d;
    logic [5:0] link_app_q, link_app_d;
    logic [7:0] rdata_q, rdata_d;
    logic [3:0] mode;
    logic [11:0] user_off;

    assign mode = conv_q[3:0];
    assign user_off = reg_addr_i - tpg_pkg::ADDR_USER_FIRST;

    // register file; soft reset returns every register to its default
    always_comb begin
        soft_d = '0;
        ddc_ctrl_d = ddc_ctrl_q;
        conv_d = conv_q;
        user_d = user_q;
        link_d = link_q;
        link_ext_d = link_ext_q;
        link_app_d = link_app_q;
        rdata_d = rdata_q;
        if (soft_q != '0) begin
            for (int i = 0; i < NDDC; i++) begin
                ddc_ctrl_d[i] = tpg_pkg::RST_VAL_REG;
            end
            for (int i = 0; i < 2 * tpg_pkg::NUM_USER_PAT; i++) begin
                user_d[i] = tpg_pkg::RST_VAL_REG;
            end
            conv_d = tpg_pkg::RST_VAL_REG;
            link_d = tpg_pkg::RST_VAL_REG;
            link_ext_d = tpg_pkg::RST_VAL_REG;
            // RQ17 leaves link test
            link_app_d = '0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == tpg_pkg::ADDR_SOFT_RESET) begin
                // RQ17 self-clearing reset
                soft_d = reg_wdata_i & tpg_pkg::SOFT_RESET_MASK;
            end
            if (reg_addr_i == tpg_pkg::ADDR_DDC0_CTRL) ddc_ctrl_d[0] = reg_wdata_i;
            if (reg_addr_i == tpg_pkg::ADDR_DDC1_CTRL) ddc_ctrl_d[1] = reg_wdata_i;
            if (reg_addr_i == tpg_pkg::ADDR_DDC2_CTRL) ddc_ctrl_d[2] = reg_wdata_i;
            if (reg_addr_i == tpg_pkg::ADDR_DDC3_CTRL) ddc_ctrl_d[3] = reg_wdata_i;
            if (reg_addr_i == tpg_pkg::ADDR_CONV_TEST) conv_d = reg_wdata_i;
            if (reg_addr_i >= tpg_pkg::ADDR_USER_FIRST && reg_addr_i <= tpg_pkg::ADDR_USER_LAST) begin
                user_d[user_off[2:0]] = reg_wdata_i;
            end
            if (reg_addr_i == tpg_pkg::ADDR_LINK_TEST) begin
                link_d = reg_wdata_i;
                // RQ17 zero does not end test
                if (reg_wdata_i != '0) begin
                    link_app_d = reg_wdata_i[5:0];
                end
            end
            if (reg_addr_i == tpg_pkg::ADDR_LINK_TEST_EXT) link_ext_d = reg_wdata_i;
        end
        if (reg_rd_i) begin
            rdata_d = '0;
            if (reg_addr_i == tpg_pkg::ADDR_SOFT_RESET) rdata_d = soft_q;
            if (reg_addr_i == tpg_pkg::ADDR_DDC0_CTRL) rdata_d = ddc_ctrl_q[0];
            if (reg_addr_i == tpg_pkg::ADDR_DDC1_CTRL) rdata_d = ddc_ctrl_q[1];
            if (reg_addr_i == tpg_pkg::ADDR_DDC2_CTRL) rdata_d = ddc_ctrl_q[2];
            if (reg_addr_i == tpg_pkg::ADDR_DDC3_CTRL) rdata_d = ddc_ctrl_q[3];
            if (reg_addr_i == tpg_pkg::ADDR_CONV_TEST) rdata_d = conv_q;
            if (reg_addr_i >= tpg_pkg::ADDR_USER_FIRST && reg_addr_i <= tpg_pkg::ADDR_USER_LAST) begin
                rdata_d = user_q[user_off[2:0]];
            end
            if (reg_addr_i == tpg_pkg::ADDR_LINK_TEST) rdata_d = link_q;
            if (reg_addr_i == tpg_pkg::ADDR_LINK_TEST_EXT) rdata_d = link_ext_q;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            soft_q <= '0;
            for (int i = 0; i < NDDC; i++) begin
                ddc_ctrl_q[i] <= tpg_pkg::RST_VAL_REG;
            end
            for (int i = 0; i < 2 * tpg_pkg::NUM_USER_PAT; i++) begin
                user_q[i] <= tpg_pkg::RST_VAL_REG;
            end
            conv_q <= tpg_pkg::RST_VAL_REG;
            link_q <= tpg_pkg::RST_VAL_REG;
            link_ext_q <= tpg_pkg::RST_VAL_REG;
            link_app_q <= '0;
            rdata_q <= '0;
        end else begin
            soft_q <= soft_d;
            ddc_ctrl_q <= ddc_ctrl_d;
            conv_q <= conv_d;
            user_q <= user_d;
            link_q <= link_d;
            link_ext_q <= link_ext_d;
            link_app_q <= link_app_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    // RQ18 link pattern select
    assign link_pattern_o = link_app_q[3:0];
    // RQ19 link injection point
    assign link_inject_o = link_app_q[5:4];
    // RQ16 extended link test field
    assign link_ext_o = link_ext_q;

    // pattern generators: 14 LFSR steps per sample; bit 0 leaves first and lands in the word's MSB
    function automatic logic [23+SW-1:0] pn_long(input logic [22:0] s);
        logic [22:0] st;
        logic [SW-1:0] w;
        st = s;
        w = '0;
        for (int k = 0; k < SW; k++) begin
            w = {w[SW-2:0], st[0]};
            st = {st[0] ^ st[5], st[22:1]};
        end
        return {st, w};
    endfunction

    function automatic logic [9+SW-1:0] pn_short(input logic [8:0] s);
        logic [8:0] st;
        logic [SW-1:0] w;
        st = s;
        w = '0;
        for (int k = 0; k < SW; k++) begin
            w = {w[SW-2:0], st[0]};
            st = {st[0] ^ st[4], st[8:1]};
        end
        return {st, w};
    endfunction

    logic [22:0] pnl_q, pnl_d;
    logic [8:0] pns_q, pns_d;
    logic [SW-1:0] ramp_q, ramp_d;
    logic phase_q, phase_d;
    logic [2:0] ucnt_q, ucnt_d;
    logic [4:0] mode_prev_q, mode_prev_d;
    logic [23+SW-1:0] pnl_nx;
    logic [9+SW-1:0] pns_nx;
    logic [SW-1:0] pat;
    logic [15:0] up_word;
    logic pn_hold, entered, step;
    logic fifo_in_ready;

    assign pnl_nx = pn_long(pnl_q);
    assign pns_nx = pn_short(pns_q);
    // RQ3 either bit holds PN at seed
    assign pn_hold = conv_q[tpg_pkg::POS_PN_RESET_A] || conv_q[tpg_pkg::POS_PN_RESET_B];
    assign entered = ({conv_q[tpg_pkg::POS_USER_SINGLE], mode} != mode_prev_q);
    // RQ4 asks for clock-only stepping; here a step needs adc_valid_i and fifo_in_ready
    assign step = adc_valid_i && fifo_in_ready;
    assign up_word = {user_q[2*ucnt_q[1:0]+1], user_q[2*ucnt_q[1:0]]};
    assign test_active_o = (mode != tpg_pkg::MODE_OFF);

    always_comb begin
        unique case (mode)
            // RQ1 off passes converter data
            tpg_pkg::MODE_OFF: pat = adc_data_i;
            // RQ8 fixed shorts
            tpg_pkg::MODE_MIDSCALE: pat = tpg_pkg::VAL_MIDSCALE;
            tpg_pkg::MODE_POS_FS: pat = tpg_pkg::VAL_POS_FS;
            tpg_pkg::MODE_NEG_FS: pat = tpg_pkg::VAL_NEG_FS;
            // RQ9 checkerboard
            tpg_pkg::MODE_CHECKER: pat = phase_q ? tpg_pkg::VAL_CHECK_B : tpg_pkg::VAL_CHECK_A;
            // RQ10 long PN word
            tpg_pkg::MODE_PN_LONG: pat = pnl_nx[SW-1:0];
            // RQ11 short PN word
            tpg_pkg::MODE_PN_SHORT: pat = pns_nx[SW-1:0];
            // RQ12 word toggle
            tpg_pkg::MODE_TOGGLE: pat = phase_q ? tpg_pkg::VAL_ONES : tpg_pkg::VAL_ZEROS;
            // RQ13 RQ14 user patterns, upper 14 bits
            tpg_pkg::MODE_USER: pat = (ucnt_q < 3'(tpg_pkg::NUM_USER_PAT)) ? up_word[15:2] : tpg_pkg::VAL_ZEROS;
            // RQ15 ramp
            tpg_pkg::MODE_RAMP: pat = ramp_q;
            // unused codes pass converter data as off does, but still raise test_active_o
            default: pat = adc_data_i;
        endcase
    end

    // RQ20 step per sample, restart on entry
    always_comb begin
        pnl_d = pnl_q;
        pns_d = pns_q;
        ramp_d = ramp_q;
        phase_d = phase_q;
        ucnt_d = ucnt_q;
        mode_prev_d = {conv_q[tpg_pkg::POS_USER_SINGLE], mode};
        if (entered) begin
            pnl_d = tpg_pkg::PN_LONG_SEED;
            pns_d = tpg_pkg::PN_SHORT_SEED;
            ramp_d = '0;
            phase_d = 1'b0;
            ucnt_d = '0;
        end else if (step) begin
            pnl_d = pnl_nx[23+SW-1:SW];
            pns_d = pns_nx[9+SW-1:SW];
            ramp_d = ramp_q + 1'b1;
            phase_d = !phase_q;
            if (ucnt_q == 3'(tpg_pkg::NUM_USER_PAT - 1) && !conv_q[tpg_pkg::POS_USER_SINGLE]) begin
                ucnt_d = '0;
            end else if (ucnt_q < 3'(tpg_pkg::NUM_USER_PAT)) begin
                ucnt_d = ucnt_q + 1'b1;
            end
        end
        if (pn_hold) begin
            pnl_d = tpg_pkg::PN_LONG_SEED;
            pns_d = tpg_pkg::PN_SHORT_SEED;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pnl_q <= tpg_pkg::PN_LONG_SEED;
            pns_q <= tpg_pkg::PN_SHORT_SEED;
            ramp_q <= '0;
            phase_q <= 1'b0;
            ucnt_q <= '0;
            mode_prev_q <= {1'b0, tpg_pkg::MODE_OFF};
        end else begin
            pnl_q <= pnl_d;
            pns_q <= pns_d;
            ramp_q <= ramp_d;
            phase_q <= phase_d;
            ucnt_q <= ucnt_d;
            mode_prev_q <= mode_prev_d;
        end
    end

    // datapath mux into the formatter FIFO
    logic [NDDC*SW-1:0] ddc_i_mux;
    logic [NDDC*SW-1:0] fifo_i_out, fifo_q_out;
    logic [SW-1:0] fifo_c_out;

    always_comb begin
        ddc_i_mux = ddc_i_data_i;
        for (int i = 0; i < NDDC; i++) begin
            // RQ5 RQ7 per-DDC enable; RQ6 only I path replaced
            if (test_active_o && ddc_mode_i && ddc_en_i[i] && ddc_ctrl_q[i][tpg_pkg::POS_DDC_TEST_EN]) begin
                ddc_i_mux[i*SW +: SW] = pat;
            end
        end
    end

    // RQ2 pattern replaces converter samples
    tpg_fifo #(
        .WIDTH(FW),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(adc_valid_i),
        .in_ready_o(fifo_in_ready),
        .in_data_i({pat, ddc_i_mux, ddc_q_data_i}),
        .out_valid_o(out_valid_o),
        .out_ready_i(out_ready_i),
        .out_data_o({fifo_c_out, fifo_i_out, fifo_q_out})
    );

    assign adc_ready_o = fifo_in_ready;
    assign out_conv_o = fifo_c_out;
    assign out_ddc_i_o = fifo_i_out;
    assign out_ddc_q_o = fifo_q_out;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_soft_write;
        reg_wr_i && reg_addr_i == tpg_pkg::ADDR_SOFT_RESET && reg_wdata_i == tpg_pkg::SOFT_RESET_MASK
            && soft_q == '0;
    endsequence

    chk_soft_self_clear: assert property (s_soft_write |=> soft_q == tpg_pkg::SOFT_RESET_MASK // RQ17
        ##1 soft_q == '0 ##0 link_app_q == '0) else $error("soft reset did not self clear");
    chk_link_zero_hold: assert property (reg_wr_i && soft_q == '0 && reg_addr_i == tpg_pkg::ADDR_LINK_TEST // RQ17
        && reg_wdata_i == '0 |=> $stable(link_app_q)) else $error("link test ended without soft reset");
    chk_link_fields: assert property (reg_wr_i && soft_q == '0 && reg_addr_i == tpg_pkg::ADDR_LINK_TEST // RQ18
        && reg_wdata_i != '0 |=> link_pattern_o == $past(reg_wdata_i[3:0])
        && link_inject_o == $past(reg_wdata_i[5:4])) else $error("link fields wrong");
    chk_off_passes_adc: assert property (mode == tpg_pkg::MODE_OFF |-> pat == adc_data_i) // RQ1
        else $error("off mode altered data");
    chk_pn_reseed: assert property (pn_hold |=> pnl_q == tpg_pkg::PN_LONG_SEED // RQ3
        && pns_q == tpg_pkg::PN_SHORT_SEED) else $error("PN not held at seed");
    chk_checker_alt: assert property (mode == tpg_pkg::MODE_CHECKER && !entered && step // RQ9
        && pat == tpg_pkg::VAL_CHECK_A ##1 mode == tpg_pkg::MODE_CHECKER |-> pat == tpg_pkg::VAL_CHECK_B)
        else $error("checkerboard stuck");
    chk_ramp_step: assert property (mode == tpg_pkg::MODE_RAMP && !entered && step // RQ15
        ##1 mode == tpg_pkg::MODE_RAMP |-> pat == SW'($past(pat) + 1'b1)) else $error("ramp step wrong");
    chk_user_single: assert property (mode == tpg_pkg::MODE_USER && conv_q[tpg_pkg::POS_USER_SINGLE] // RQ14
        && ucnt_q == 3'(tpg_pkg::NUM_USER_PAT) |-> pat == tpg_pkg::VAL_ZEROS) else $error("single not zero");
    chk_user_wrap: assert property (mode == tpg_pkg::MODE_USER && !conv_q[tpg_pkg::POS_USER_SINGLE] && !entered // RQ13
        && step && ucnt_q == 3'd3 ##1 mode == tpg_pkg::MODE_USER |-> ucnt_q == '0) else $error("repeat no wrap");
    chk_q_untouched: assert property (adc_valid_i && fifo_in_ready && !out_valid_o // RQ6
        |=> out_ddc_q_o == $past(ddc_q_data_i)) else $error("Q path altered");
    chk_entry_restart: assert property (entered |=> ramp_q == '0 && ucnt_q == '0 && !phase_q) // RQ20
        else $error("generators not restarted");
endmodule

// ==== dv/fmt_sink.sv ====
// output formatter stand-in: takes fifo words and keeps them in arrival order.
// assumes tpg_top's output handshake; stall_i lets the bench back-pressure it.
`timescale 1ns/1ps

module fmt_sink (
    input wire logic clk_i,
    input wire logic stall_i,
    input wire logic valid_i,
    input wire logic [13:0] conv_i,
    input wire logic [55:0] ddc_i_i,
    input wire logic [55:0] ddc_q_i,
    output logic ready_o
);
    logic [125:0] words[$];

    initial begin
        ready_o = 1'b0;
    end

    // ready moves only on the falling edge so it never races the sampling edge
    always @(negedge clk_i) begin
        ready_o <= !stall_i;
    end

    always @(posedge clk_i) begin
        if (valid_i && ready_o) begin
            words.push_back({conv_i, ddc_i_i, ddc_q_i});
        end
    end
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench for tpg_top with a formatter model on its output side.
// assumes the byte register port and sample stream of tpg_top on one clock.
`timescale 1ns/1ps

module tb_top;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [11:0] reg_addr_i = 12'h000;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic ddc_mode_i = 1'b0;
    logic [3:0] ddc_en_i = 4'h0;
    logic adc_valid_i = 1'b0;
    logic adc_ready_o;
    logic [13:0] adc_data_i = 14'h0123;
    logic [55:0] ddc_i_data_i = {4{14'h0456}};
    logic [55:0] ddc_q_data_i = {4{14'h0789}};
    logic out_valid_o;
    logic out_ready_i;
    logic [13:0] out_conv_o;
    logic [55:0] out_ddc_i_o;
    logic [55:0] out_ddc_q_o;
    logic test_active_o;
    logic [3:0] link_pattern_o;
    logic [1:0] link_inject_o;
    logic [7:0] link_ext_o;
    logic stall = 1'b0;
    int fail_count = 0;
    int checks_done = 0;

    tpg_top uut (.clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
        .ddc_mode_i, .ddc_en_i, .adc_valid_i, .adc_ready_o, .adc_data_i, .ddc_i_data_i, .ddc_q_data_i,
        .out_valid_o, .out_ready_i, .out_conv_o, .out_ddc_i_o, .out_ddc_q_o, .test_active_o,
        .link_pattern_o, .link_inject_o, .link_ext_o);

    fmt_sink sink_m (.clk_i(clk_i), .stall_i(stall), .valid_i(out_valid_o), .conv_i(out_conv_o),
        .ddc_i_i(out_ddc_i_o), .ddc_q_i(out_ddc_q_o), .ready_o(out_ready_i));

    always #12.5 clk_i = ~clk_i;

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [125:0] got, input logic [125:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge clk_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clk_i);
        reg_wr_i = 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        @(negedge clk_i);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(negedge clk_i);
        reg_rd_i = 1'b0;
        chk(126'(reg_rdata_o), 126'(e));
    endtask

    // holds valid until the fifo has taken n samples; ready is read off-edge
    task automatic push(input int n);
        int k;
        k = 0;
        sink_m.words.delete();
        @(negedge clk_i);
        adc_valid_i = 1'b1;
        while (k < n) begin
            if (adc_ready_o === 1'b1) k++;
            @(negedge clk_i);
        end
        adc_valid_i = 1'b0;
    endtask

    task automatic drain(input logic [13:0] e[$]);
        int t;
        t = 0;
        while (sink_m.words.size() < e.size() && t < 300) begin
            @(negedge clk_i);
            t++;
        end
        chk(126'(sink_m.words.size()), 126'(e.size()));
        for (int i = 0; i < e.size() && i < sink_m.words.size(); i++) begin
            chk(126'(sink_m.words[i][125:112]), 126'(e[i]));
        end
    endtask

    task automatic pat(input logic [7:0] mode, input logic [13:0] e[$]);
        wr(tpg_pkg::ADDR_CONV_TEST, mode);
        repeat (3) @(negedge clk_i);
        push(e.size());
        drain(e);
    endtask

    task automatic test_reset();
        chk(126'(test_active_o), 126'(0));
        rd_chk(tpg_pkg::ADDR_CONV_TEST, 8'h00);
        rd_chk(12'h123, 8'h00);
        rd_chk(tpg_pkg::ADDR_DDC2_CTRL, 8'h00);
        rd_chk(tpg_pkg::ADDR_LINK_TEST, 8'h00);
    endtask

    task automatic test_fixed();
        pat(8'h00, {14'h0123, 14'h0123, 14'h0123});
        pat(8'h0B, {14'h0123, 14'h0123});
        pat(8'h01, {14'h0000, 14'h0000, 14'h0000});
        chk(126'(test_active_o), 126'(1));
        pat(8'h02, {14'h1FFF, 14'h1FFF, 14'h1FFF});
        pat(8'h03, {14'h2000, 14'h2000, 14'h2000});
        pat(8'h04, {14'h1555, 14'h2AAA, 14'h1555, 14'h2AAA});
        pat(8'h07, {14'h0000, 14'h3FFF, 14'h0000, 14'h3FFF});
        pat(8'h0F, {14'h0000, 14'h0001, 14'h0002, 14'h0003, 14'h0004});
    endtask

    task automatic test_pn();
        pat(8'h05, {14'h3FD7, 14'h0002, 14'h26E0, 14'h0A3D, 14'h1CA6});
        wr(tpg_pkg::ADDR_CONV_TEST, 8'h15);
        pat(8'h05, {14'h3FD7, 14'h0002});
        pat(8'h06, {14'h125B, 14'h3C9A, 14'h2660, 14'h0C65, 14'h0697});
        wr(tpg_pkg::ADDR_CONV_TEST, 8'h26);
        pat(8'h06, {14'h125B, 14'h3C9A});
    endtask

    task automatic test_user();
        logic [13:0] rep[$];
        logic [13:0] one[$];
        logic [15:0] up;
        for (int i = 0; i < 8; i++) begin
            wr(tpg_pkg::ADDR_USER_FIRST + 12'(i), 8'hA0 + 8'(i));
        end
        for (int k = 0; k < 6; k++) begin
            up = {8'hA1 + 8'(2 * (k % 4)), 8'hA0 + 8'(2 * (k % 4))};
            rep.push_back(up[15:2]);
            one.push_back(k < 4 ? up[15:2] : 14'h0000);
        end
        rd_chk(tpg_pkg::ADDR_USER_LAST, 8'hA7);
        pat(8'h08, rep);
        pat(8'h88, one);
    endtask

    task automatic test_ddc();
        wr(tpg_pkg::ADDR_DDC0_CTRL, 8'h01);
        wr(tpg_pkg::ADDR_DDC3_CTRL, 8'h01);
        rd_chk(tpg_pkg::ADDR_DDC3_CTRL, 8'h01);
        ddc_mode_i = 1'b1;
        ddc_en_i = 4'hF;
        pat(8'h02, {14'h1FFF});
        chk(126'(sink_m.words[0][111:56]), 126'({14'h1FFF, 14'h0456, 14'h0456, 14'h1FFF}));
        chk(126'(sink_m.words[0][55:0]), 126'({4{14'h0789}}));
        ddc_en_i = 4'h7;
        pat(8'h03, {14'h2000});
        chk(126'(sink_m.words[0][111:56]), 126'({14'h0456, 14'h0456, 14'h0456, 14'h2000}));
        ddc_mode_i = 1'b0;
    endtask

    task automatic test_fifo();
        stall = 1'b1;
        wr(tpg_pkg::ADDR_CONV_TEST, 8'h0F);
        repeat (3) @(negedge clk_i);
        push(tpg_pkg::FIFO_DEPTH);
        @(negedge clk_i);
        chk(126'({adc_ready_o, out_valid_o}), 126'(2'b01));
        stall = 1'b0;
        drain({14'h0, 14'h1, 14'h2, 14'h3, 14'h4, 14'h5, 14'h6, 14'h7});
    endtask

    task automatic test_link();
        wr(tpg_pkg::ADDR_LINK_TEST, 8'h13);
        chk(126'({link_inject_o, link_pattern_o}), 126'(6'h13));
        wr(tpg_pkg::ADDR_LINK_TEST_EXT, 8'h5A);
        chk(126'(link_ext_o), 126'(8'h5A));
        wr(tpg_pkg::ADDR_LINK_TEST, 8'h00);
        chk(126'(link_pattern_o), 126'(4'h3));
        wr(tpg_pkg::ADDR_SOFT_RESET, 8'h81);
        repeat (4) @(negedge clk_i);
        rd_chk(tpg_pkg::ADDR_SOFT_RESET, 8'h00);
        rd_chk(tpg_pkg::ADDR_CONV_TEST, 8'h00);
        chk(126'({link_ext_o, link_inject_o, link_pattern_o}), 126'(0));
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
        rst_n_i = 1'b1;
        test_reset();
        test_fixed();
        test_pn();
        test_user();
        test_ddc();
        test_fifo();
        test_link();
        test_done();
    end

    // the whole sequence needs well under a thousand cycles
    initial begin
        #(25ns * 20000);
        fail_count++;
        test_done();
    end
endmodule
